//--- rtl/cuw_consts.svh
// Constants for the cache-unit bus write and acknowledge master port.
`ifndef CUW_CONSTS_SVH
`define CUW_CONSTS_SVH
`define CUW_DATA_W      64
`define CUW_WORD_W      32
`define CUW_ADDR_W      32
`define CUW_LINE_WORDS  8
`define CUW_FIFO_DEPTH  8
`define CUW_WIDE_BEATS  4'h4
`define CUW_NARROW_BEATS 4'h8
`define CUW_MAX_READS   2'h2
`define CUW_REISSUE_GAP 2'h2
`endif

//--- rtl/cuw_pkg.sv
// Types for the cache-unit bus write and acknowledge master port.
package cuw_pkg;
  typedef enum logic [1:0] {
    CUW_IDLE = 2'b00,
    CUW_REQ  = 2'b01,
    CUW_DATA = 2'b10,
    CUW_GAP  = 2'b11
  } cuw_wstate_t;
  typedef enum logic [1:0] {
    CUW_RIDLE = 2'b00,
    CUW_RREQ  = 2'b01,
    CUW_RGAP  = 2'b10
  } cuw_rstate_t;
endpackage

//--- rtl/cuw_fifo.sv
// Line-data FIFO with valid and ready on both sides, registered read data.
`timescale 1ns/10ps
module cuw_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic             ov_q, ov_d;
  logic             push, pop, load;

  // The head is kept in a register so the bus sees data from a flip-flop.
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    load = (cnt_q != '0) && (!ov_q || pop);
    wp_d = push ? wp_q + AW'(1) : wp_q;
    rp_d = load ? rp_q + AW'(1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
    ov_d = load ? 1'b1 : (pop ? 1'b0 : ov_q);
    od_d = load ? mem_q[rp_q] : od_q;
  end

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = ov_q;
  assign out_data  = od_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else if (ce) begin
      if (push) begin
        mem_q[wp_q] <= in_data;
      end
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      ov_q <= ov_d;
      od_q <= od_d;
    end
  end
endmodule

//--- rtl/cuw_master.sv
// Data-cache-unit bus master: write data, address acknowledge and request pacing.
`timescale 1ns/10ps
`include "cuw_consts.svh"
module cuw_master (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  // Core side: write command.
  input  wire logic                   wr_cmd_valid,
  output logic                        wr_cmd_ready,
  input  wire logic                   wr_cmd_line,
  input  wire logic [`CUW_ADDR_W-1:0] wr_cmd_addr,
  input  wire logic [7:0]             wr_cmd_be,
  input  wire logic [3:0]             wr_cmd_attr,
  input  wire logic [`CUW_WORD_W-1:0] wr_cmd_word,
  // Core side: line words, word 0 first.
  input  wire logic                   line_valid,
  output logic                        line_ready,
  input  wire logic [`CUW_WORD_W-1:0] line_word,
  // Core side: read command and completion.
  input  wire logic                   rd_cmd_valid,
  output logic                        rd_cmd_ready,
  input  wire logic                   rd_cmd_line,
  input  wire logic [`CUW_ADDR_W-1:0] rd_cmd_addr,
  input  wire logic [7:0]             rd_cmd_be,
  input  wire logic [3:0]             rd_cmd_attr,
  input  wire logic                   rd_done,
  input  wire logic                   abort_req,
  output logic                        wr_done,
  // Bus side.
  output logic                        data_access_request,
  output logic                        read_not_write,
  output logic [`CUW_ADDR_W-1:0]      request_address_bus,
  output logic                        line_transfer_size,
  output logic                        cacheable_attr,
  output logic                        write_through_attr,
  output logic                        user_storage_attr,
  output logic                        guarded_attr,
  output logic [7:0]                  byte_lane_enables,
  output logic                        request_abort,
  output logic [`CUW_DATA_W-1:0]      write_data_bus,
  input  wire logic                   slave_address_ack,
  input  wire logic                   slave_width_flag,
  input  wire logic                   write_data_ack
);
  logic in_rd_s1, in_rd_s2, in_rd_s3;
  logic rdd_q, rdd_i;

  // The read completion level is staged like a pin: change taken when two stages agree.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      {in_rd_s1, in_rd_s2, in_rd_s3} <= 3'h0;
      rdd_q <= 1'b0;
    end else if (ce) begin
      {in_rd_s1, in_rd_s2, in_rd_s3} <= {rd_done, in_rd_s1, in_rd_s2};
      rdd_q <= rdd_i;
    end
  end

  always_comb begin
    rdd_i = (in_rd_s2 == in_rd_s3) ? in_rd_s3 : rdd_q;
  end

  logic ack_p, wdk_p, rdd_p;
  logic rdd_dly;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdd_dly <= 1'b0;
    end else if (ce) begin
      rdd_dly <= rdd_q;
    end
  end
  // Slave strobes share the bus clock and last one cycle, so staging them would break pacing.
  assign ack_p = slave_address_ack;
  assign wdk_p = write_data_ack;
  assign rdd_p = rdd_q && !rdd_dly;

  function automatic logic [`CUW_DATA_W-1:0] beat_word(input logic hi_lo,
                                                       input logic [`CUW_WORD_W-1:0] w);
    beat_word = hi_lo ? {w, w} : {w, `CUW_WORD_W'(0)};
  endfunction

  // Line words stage through the FIFO so the core can run ahead of the slave.
  logic                   fifo_ov, fifo_pop;
  logic [`CUW_WORD_W-1:0] fifo_od;
  cuw_fifo #(.WIDTH(`CUW_WORD_W), .DEPTH(`CUW_FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (line_valid),
    .in_ready  (line_ready),
    .in_data   (line_word),
    .out_valid (fifo_ov),
    .out_ready (fifo_pop),
    .out_data  (fifo_od)
  );

  cuw_pkg::cuw_wstate_t   ws_q, ws_d;
  cuw_pkg::cuw_rstate_t   rs_q, rs_d;
  logic                   wr_out_q, wr_out_d;
  logic [1:0]             rd_out_q, rd_out_d;
  logic [1:0]             gap_q, gap_d;
  logic [3:0]             beats_q, beats_d;
  logic                   wide_q, wide_d, line_q, line_d;
  logic [`CUW_WORD_W-1:0] hold_q, hold_d;
  logic [`CUW_DATA_W-1:0] wdb_q, wdb_d;
  logic                   even_q, even_d;
  logic                   owner_wr_q, owner_wr_d;
  logic [`CUW_ADDR_W-1:0] addr_q, addr_d;
  logic [7:0]             be_q, be_d;
  logic [3:0]             attr_q, attr_d;
  logic                   req_q, req_d, abt_q, abt_d, done_q, done_d;
  logic                   can_wr, can_rd;

  always_comb begin
    ws_d = ws_q;
    rs_d = rs_q;
    wr_out_d = wr_out_q;
    rd_out_d = rd_out_q;
    gap_d = (gap_q != 2'h0) ? gap_q - 2'h1 : 2'h0;
    beats_d = beats_q;
    wide_d = wide_q;
    line_d = line_q;
    hold_d = hold_q;
    wdb_d = wdb_q;
    even_d = even_q;
    owner_wr_d = owner_wr_q;
    addr_d = addr_q;
    be_d = be_q;
    attr_d = attr_q;
    req_d = req_q;
    abt_d = 1'b0;
    done_d = 1'b0;
    fifo_pop = 1'b0;
    // At most one write and two reads outstanding, with a gap before reissue.
    can_wr = !wr_out_q && (gap_q == 2'h0) && !req_q;
    can_rd = (rd_out_q < `CUW_MAX_READS) && (gap_q == 2'h0) && !req_q;
    wr_cmd_ready = 1'b0;
    rd_cmd_ready = 1'b0;
    if (req_q) begin
      // An abort that meets the acknowledge comes too late to signal; the transfer goes on.
      if (abort_req && !abt_q && !ack_p) begin
        abt_d = 1'b1;
      end
      if (ack_p || abt_q) begin
        req_d = 1'b0;
        if (abt_q) begin
          if (owner_wr_q) begin
            ws_d = cuw_pkg::CUW_IDLE;
            wr_out_d = 1'b0;
          end else begin
            rs_d = cuw_pkg::CUW_RIDLE;
          end
        end else if (owner_wr_q) begin
          ws_d = cuw_pkg::CUW_DATA;
          wide_d = slave_width_flag;
          wr_out_d = 1'b1;
          // A slave may take single-word data in the address acknowledge cycle.
          if (!line_q && wdk_p) begin
            ws_d = cuw_pkg::CUW_IDLE;
            wr_out_d = 1'b0;
            done_d = 1'b1;
            gap_d = `CUW_REISSUE_GAP;
          end
        end else begin
          rs_d = cuw_pkg::CUW_RIDLE;
          rd_out_d = rd_out_q + 2'h1;
        end
      end
    end else if (ws_q == cuw_pkg::CUW_IDLE && wr_cmd_valid && can_wr) begin
      wr_cmd_ready = 1'b1;
      ws_d = cuw_pkg::CUW_REQ;
      owner_wr_d = 1'b1;
      req_d = 1'b1;
      line_d = wr_cmd_line;
      addr_d = wr_cmd_addr;
      be_d = wr_cmd_be;
      attr_d = wr_cmd_attr;
      beats_d = 4'h0;
      // Single-word data stands on both halves from the request onward.
      wdb_d = beat_word(1'b1, wr_cmd_word);
      hold_d = fifo_od;
      even_d = 1'b1;
    end else if (rs_q == cuw_pkg::CUW_RIDLE && rd_cmd_valid && can_rd) begin
      rd_cmd_ready = 1'b1;
      rs_d = cuw_pkg::CUW_RREQ;
      owner_wr_d = 1'b0;
      req_d = 1'b1;
      line_d = rd_cmd_line;
      addr_d = rd_cmd_addr;
      be_d = rd_cmd_be;
      attr_d = rd_cmd_attr;
    end
    // Line data: the first word is taken from the FIFO in CUW_DATA, the cycle after the address is acknowledged.
    if (ws_q == cuw_pkg::CUW_DATA && line_q) begin
      if (beats_q == 4'h0 && fifo_ov && !(even_q == 1'b0)) begin
        if (wide_q) begin
          if (even_q && wdb_q[`CUW_WORD_W-1:0] == '0 && beats_q == 4'h0 && !fifo_pop) begin
            hold_d = fifo_od;
          end
        end
      end
    end
    if (ws_q == cuw_pkg::CUW_DATA) begin
      if (!line_q) begin
        if (wdk_p) begin
          ws_d = cuw_pkg::CUW_IDLE;
          wr_out_d = 1'b0;
          done_d = 1'b1;
          gap_d = `CUW_REISSUE_GAP;
        end
      end else if (even_q) begin
        // Assemble the next beat: wide takes two words, narrow one.
        if (fifo_ov) begin
          fifo_pop = 1'b1;
          if (wide_q) begin
            hold_d = fifo_od;
            even_d = 1'b0;
          end else begin
            wdb_d = beat_word(1'b0, fifo_od);
            even_d = 1'b0;
            ws_d = cuw_pkg::CUW_GAP;
          end
        end
      end else if (fifo_ov) begin
        fifo_pop = 1'b1;
        wdb_d = {hold_q, fifo_od};
        ws_d = cuw_pkg::CUW_GAP;
      end
    end
    // Beat presented: hold until acknowledged, then fetch the next.
    if (ws_q == cuw_pkg::CUW_GAP && wdk_p) begin
      beats_d = beats_q + 4'h1;
      even_d = 1'b1;
      if (beats_q + 4'h1 == (wide_q ? `CUW_WIDE_BEATS : `CUW_NARROW_BEATS)) begin
        ws_d = cuw_pkg::CUW_IDLE;
        wr_out_d = 1'b0;
        done_d = 1'b1;
        gap_d = `CUW_REISSUE_GAP;
      end else begin
        ws_d = cuw_pkg::CUW_DATA;
      end
    end
    if (rdd_p && rd_out_q != 2'h0 && !(req_q && ack_p && !owner_wr_q && !abt_q)) begin
      rd_out_d = rd_out_q - 2'h1;
      gap_d = `CUW_REISSUE_GAP;
    end else if (rdd_p && rd_out_q != 2'h0) begin
      rd_out_d = rd_out_q;
      gap_d = `CUW_REISSUE_GAP;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ws_q <= cuw_pkg::CUW_IDLE;
      rs_q <= cuw_pkg::CUW_RIDLE;
      wr_out_q <= 1'b0;
      rd_out_q <= 2'h0;
      gap_q <= 2'h0;
      beats_q <= 4'h0;
      wide_q <= 1'b0;
      line_q <= 1'b0;
      hold_q <= '0;
      wdb_q <= '0;
      even_q <= 1'b1;
      owner_wr_q <= 1'b0;
      addr_q <= '0;
      be_q <= 8'h00;
      attr_q <= 4'h0;
      req_q <= 1'b0;
      abt_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      ws_q <= ws_d;
      rs_q <= rs_d;
      wr_out_q <= wr_out_d;
      rd_out_q <= rd_out_d;
      gap_q <= gap_d;
      beats_q <= beats_d;
      wide_q <= wide_d;
      line_q <= line_d;
      hold_q <= hold_d;
      wdb_q <= wdb_d;
      even_q <= even_d;
      owner_wr_q <= owner_wr_d;
      addr_q <= addr_d;
      be_q <= be_d;
      attr_q <= attr_d;
      req_q <= req_d;
      abt_q <= abt_d;
      done_q <= done_d;
    end
  end

  assign data_access_request = req_q;
  assign read_not_write      = !owner_wr_q;
  assign request_address_bus = addr_q;
  assign line_transfer_size  = line_q;
  assign {cacheable_attr, write_through_attr, user_storage_attr, guarded_attr} = attr_q;
  // Enables carry no meaning on line transfers, so they are driven to zero then.
  assign byte_lane_enables   = line_q ? 8'h00 : be_q;
  assign request_abort       = abt_q;
  assign write_data_bus      = wdb_q;
  assign wr_done             = done_q;

  a_outstanding_cap : assert property (@(posedge clock) disable iff (!nrst)
    rd_out_q <= `CUW_MAX_READS) else $error("too many reads outstanding");
  a_req_gap_ack : assert property (@(posedge clock) disable iff (!nrst)
    ce && req_q && ack_p && !abt_q |=> !req_q) else $error("request not dropped");
  a_abort_drop : assert property (@(posedge clock) disable iff (!nrst)
    ce && abt_q |=> !req_q) else $error("request held after abort");
  a_single_dup : assert property (@(posedge clock) disable iff (!nrst)
    ws_q == cuw_pkg::CUW_DATA && !line_q |-> wdb_q[63:32] == wdb_q[31:0])
    else $error("single word not replicated");
  a_single_hold : assert property (@(posedge clock) disable iff (!nrst)
    ce && ws_q == cuw_pkg::CUW_DATA && !line_q && !wdk_p |=> $stable(wdb_q))
    else $error("single data changed early");
  a_beat_hold : assert property (@(posedge clock) disable iff (!nrst)
    ce && ws_q == cuw_pkg::CUW_GAP && !wdk_p |=> $stable(wdb_q))
    else $error("line beat changed early");
  a_narrow_upper : assert property (@(posedge clock) disable iff (!nrst)
    ws_q == cuw_pkg::CUW_GAP && !wide_q |-> wdb_q[31:0] == 32'h0)
    else $error("narrow beat on low half");
  a_beat_limit : assert property (@(posedge clock) disable iff (!nrst)
    beats_q <= `CUW_NARROW_BEATS && (!wide_q || beats_q <= `CUW_WIDE_BEATS))
    else $error("beat count overrun");
endmodule

//--- test/cuw_slave_model.sv
// Behavioural bus slave that answers the master port's requests and records write beats.
`timescale 1ns/10ps
`include "cuw_consts.svh"
module cuw_slave_model (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   wide,
  input  wire logic [7:0]             ack_dly,
  input  wire logic                   data_access_request,
  input  wire logic                   read_not_write,
  input  wire logic [`CUW_ADDR_W-1:0] request_address_bus,
  input  wire logic                   line_transfer_size,
  input  wire logic [3:0]             attrs,
  input  wire logic [7:0]             byte_lane_enables,
  input  wire logic                   request_abort,
  input  wire logic [`CUW_DATA_W-1:0] write_data_bus,
  output logic                        slave_address_ack,
  output logic                        slave_width_flag,
  output logic                        write_data_ack
);
  logic [`CUW_DATA_W-1:0] beats[$];
  logic [`CUW_DATA_W-1:0] first_bus;
  logic [`CUW_DATA_W-1:0] stored;
  logic                   early;
  logic [`CUW_ADDR_W-1:0] cap_addr;
  logic [5:0]             cap_ctl;
  logic [7:0]             cap_be;
  logic                   aborted;
  logic                   abort_seen_q;
  int                     n_addr;
  int                     abort_viol = 0;
  int                     nbeat;

  // Only the enabled byte lanes of a single word reach storage.
  function automatic logic [`CUW_DATA_W-1:0] lanes(input logic [7:0] be,
                                                   input logic [`CUW_DATA_W-1:0] d);
    int b;
    lanes = '0;
    for (b = 0; b < 8; b++) begin
      if (be[b]) lanes[8*b +: 8] = d[8*b +: 8];
    end
  endfunction

  // Each request is served to its end before the next one is looked at.
  task automatic serve();
    int i;
    repeat (ack_dly) @(posedge clock);
    if (data_access_request !== 1'h1) return;
    slave_address_ack <= 1'h1;
    slave_width_flag  <= wide;
    // With a delay of one, single-word data is also taken in the acknowledge cycle.
    early = ack_dly == 8'h01 && read_not_write === 1'h0 && line_transfer_size === 1'h0;
    write_data_ack    <= early;
    @(posedge clock);
    cap_addr  = request_address_bus;
    cap_ctl   = {read_not_write, line_transfer_size, attrs};
    cap_be    = byte_lane_enables;
    first_bus = write_data_bus;
    aborted   = request_abort;
    n_addr++;
    slave_address_ack <= 1'h0;
    // The flag means nothing outside the ack cycle, so it is inverted to catch late sampling.
    slave_width_flag  <= ~wide;
    write_data_ack    <= 1'h0;
    if (early && aborted !== 1'h1) begin
      beats.push_back(write_data_bus);
      stored = lanes(cap_be, write_data_bus);
    end
    for (i = 0; i < 40 && data_access_request === 1'h1; i++) @(posedge clock);
    nbeat = early ? 0 : (cap_ctl[4] ? (wide ? 4 : 8) : 1);
    if (cap_ctl[5] === 1'h0 && aborted !== 1'h1) begin
      repeat (nbeat) begin
        repeat (2) @(posedge clock);
        write_data_ack <= 1'h1;
        @(posedge clock);
        beats.push_back(write_data_bus);
        if (cap_ctl[4] === 1'h0) stored = lanes(cap_be, write_data_bus);
        write_data_ack <= 1'h0;
        // A gap between beats gives the master time to stage the next beat.
        repeat (8) @(posedge clock);
      end
    end
  endtask

  initial begin
    slave_address_ack = 1'h0;
    write_data_ack    = 1'h0;
    slave_width_flag  = 1'h0;
    n_addr            = 0;
    forever begin
      @(posedge clock);
      if (nrst === 1'h1 && data_access_request === 1'h1) serve();
    end
  end

  always @(posedge clock) begin
    if (abort_seen_q === 1'h1 && data_access_request === 1'h1) abort_viol++;
    abort_seen_q <= request_abort;
  end
endmodule

//--- test/cuw_master_tb.sv
// Self-checking bench for the cache-unit write master against a behavioural slave.
`timescale 1ns/10ps
`include "cuw_consts.svh"
module cuw_master_tb;
  typedef struct {
    logic        line;
    logic        wide;
    logic [7:0]  dly;
    logic [31:0] addr;
    logic [7:0]  be;
    logic [3:0]  attr;
    logic [31:0] w;
    logic [63:0] kept;
  } cuw_row_t;
  logic        clock, nrst, ce, wide, rd_done, abort_req;
  logic [7:0]  ack_dly;
  logic        wr_cmd_valid, wr_cmd_ready, wr_cmd_line, line_valid, line_ready;
  logic [31:0] wr_cmd_addr, wr_cmd_word, line_word, rd_cmd_addr, request_address_bus;
  logic [7:0]  wr_cmd_be, rd_cmd_be, byte_lane_enables;
  logic [3:0]  wr_cmd_attr, rd_cmd_attr;
  logic        rd_cmd_valid, rd_cmd_ready, rd_cmd_line, wr_done;
  logic        data_access_request, read_not_write, line_transfer_size, request_abort;
  logic        cacheable_attr, write_through_attr, user_storage_attr, guarded_attr;
  logic [63:0] write_data_bus;
  logic        slave_address_ack, slave_width_flag, write_data_ack;
  int          failures, cmp_count, n0;
  cuw_row_t    rows[5] = '{
    '{1'h0, 1'h1, 8'h00, 32'h0000_1004, 8'h0F, 4'hA, 32'hCAFE_0001, 64'h0000_0000_CAFE_0001},
    '{1'h0, 1'h0, 8'h03, 32'h0000_2000, 8'hF0, 4'h5, 32'h1234_5678, 64'h1234_5678_0000_0000},
    '{1'h1, 1'h1, 8'h02, 32'h0000_3000, 8'hFF, 4'h8, 32'hA000_0000, 64'h0},
    '{1'h1, 1'h0, 8'h00, 32'h0000_4020, 8'hFF, 4'h1, 32'hB000_0010, 64'h0},
    '{1'h0, 1'h1, 8'h01, 32'h0000_1008, 8'hC0, 4'h3, 32'h7E11_5A3C, 64'h7E11_0000_0000_0000}};

  cuw_master dut (
    .clock, .nrst, .ce, .wr_cmd_valid, .wr_cmd_ready, .wr_cmd_line, .wr_cmd_addr,
    .wr_cmd_be, .wr_cmd_attr, .wr_cmd_word, .line_valid, .line_ready, .line_word,
    .rd_cmd_valid, .rd_cmd_ready, .rd_cmd_line, .rd_cmd_addr, .rd_cmd_be, .rd_cmd_attr,
    .rd_done, .abort_req, .wr_done, .data_access_request, .read_not_write,
    .request_address_bus, .line_transfer_size, .cacheable_attr, .write_through_attr,
    .user_storage_attr, .guarded_attr, .byte_lane_enables, .request_abort, .write_data_bus,
    .slave_address_ack, .slave_width_flag, .write_data_ack);

  cuw_slave_model slave (
    .clock, .nrst, .wide, .ack_dly, .data_access_request, .read_not_write,
    .request_address_bus, .line_transfer_size,
    .attrs({cacheable_attr, write_through_attr, user_storage_attr, guarded_attr}),
    .byte_lane_enables, .request_abort, .write_data_bus, .slave_address_ack,
    .slave_width_flag, .write_data_ack);

  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic bail();
    failures++;
    summarize();
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits at falling edges for a condition; which selects the condition.
  task automatic wait_for(input int which);
    int i;
    for (i = 0; i < 400; i++) begin
      #1;
      if ((which == 0 && wr_cmd_ready === 1'h1) || (which == 1 && line_ready === 1'h1) ||
          (which == 2 && rd_cmd_ready === 1'h1) || (which == 3 && wr_done === 1'h1) ||
          (which == 4 && data_access_request === 1'h1) ||
          (which == 5 && request_abort === 1'h1) || (which == 6 && slave.n_addr != n0)) break;
      @(negedge clock);
    end
    if (i == 400) bail();
    @(negedge clock);
  endtask

  task automatic pulse_done();
    rd_done = 1'h1;
    repeat (2) @(negedge clock);
    rd_done = 1'h0;
    repeat (4) @(negedge clock);
  endtask

  initial begin
    cuw_row_t r;
    int       k, n;
    {nrst, wide, rd_done, abort_req, wr_cmd_valid, wr_cmd_line, line_valid} = 7'h00;
    {rd_cmd_valid, rd_cmd_line, wr_cmd_addr, wr_cmd_word, line_word, rd_cmd_addr} = 130'h0;
    {wr_cmd_be, rd_cmd_be, wr_cmd_attr, rd_cmd_attr, ack_dly} = 32'h0;
    ce = 1'h1;
    failures = 0;
    cmp_count = 0;
    repeat (20) @(posedge clock);
    @(negedge clock);
    check({62'h0, data_access_request, request_abort}, 64'h0);
    check(write_data_bus, 64'h0);
    check(64'(byte_lane_enables), 64'h0);
    nrst = 1'h1;
    @(negedge clock);
    foreach (rows[i]) begin
      r = rows[i];
      wide = r.wide;
      ack_dly = r.dly;
      slave.beats.delete();
      if (r.line) begin
        line_valid = 1'h1;
        for (k = 0; k < 8; k++) begin
          line_word = r.w + 32'(k);
          wait_for(1);
        end
        line_valid = 1'h0;
        check(64'(data_access_request), 64'h0);
      end
      {wr_cmd_line, wr_cmd_addr, wr_cmd_be, wr_cmd_attr, wr_cmd_word} = {r.line, r.addr, r.be,
                                                                         r.attr, r.w};
      wr_cmd_valid = 1'h1;
      wait_for(0);
      wr_cmd_valid = 1'h0;
      wait_for(3);
      check(64'(slave.cap_addr), 64'(r.addr));
      check(64'(slave.cap_ctl), {58'h0, 1'h0, r.line, r.attr});
      check(64'(slave.cap_be), r.line ? 64'h0 : 64'(r.be));
      n = r.line ? (r.wide ? 4 : 8) : 1;
      check(64'(slave.beats.size()), 64'(n));
      if (!r.line) check(slave.first_bus, {r.w, r.w});
      if (!r.line) check(slave.stored, r.kept);
      for (k = 0; k < n && k < slave.beats.size(); k++) begin
        if (!r.line) check(slave.beats[k], {r.w, r.w});
        else if (r.wide) check(slave.beats[k], {r.w + 32'(2*k), r.w + 32'(2*k+1)});
        else check({32'h0, slave.beats[k][63:32]}, {32'h0, r.w + 32'(k)});
      end
    end
    // Two reads may be outstanding; the third is held back until the first completes.
    {rd_cmd_line, rd_cmd_be, rd_cmd_attr} = {1'h0, 8'hF0, 4'h2};
    for (k = 0; k < 3; k++) begin
      n0 = slave.n_addr;
      rd_cmd_addr = 32'h0000_5000 + 32'(4*k);
      rd_cmd_valid = 1'h1;
      if (k == 2) begin
        repeat (40) @(negedge clock);
        check(64'(slave.n_addr), 64'(n0));
        pulse_done();
      end
      wait_for(2);
      rd_cmd_valid = 1'h0;
      wait_for(6);
      check(64'(slave.cap_ctl[5]), 64'h1);
    end
    pulse_done();
    pulse_done();
    // A slow slave lets the abort land before the address is acknowledged.
    ack_dly = 8'h3C;
    slave.beats.delete();
    {wr_cmd_line, wr_cmd_addr} = {1'h0, 32'h0000_6000};
    {wr_cmd_be, wr_cmd_word} = {8'h0F, 32'h5A5A_0F0F};
    wr_cmd_valid = 1'h1;
    wait_for(0);
    wr_cmd_valid = 1'h0;
    wait_for(4);
    abort_req = 1'h1;
    wait_for(5);
    abort_req = 1'h0;
    repeat (100) @(negedge clock);
    check(64'(data_access_request), 64'h0);
    check(64'(slave.abort_viol), 64'h0);
    check(64'(slave.beats.size()), 64'h0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clock);
    bail();
  end
endmodule
